/* File: verilog/gssf_top.sv */
// Genlock status register bank with per-standard reference filter
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
// Functional notes
// - A standard whose disable bit is high is never recognised; reference lock still follows clock lock for it when F, V and H are all masked.
// - The vector spans three registers: bits 15-0, 31-16 and 47-32.
// - Reference lock is high only if bit 1 is high and bits 4-2 are each high or masked.
// - The active-low lock-lost pin is the inverse of reference lock.
// - Field lock is high when field timing is locked to field sync.
// - Without field sync the field-lock flag copies the vertical-lock flag.
// - Vertical lock is high when vertical timing is locked to vertical sync.
// - Horizontal lock is high when horizontal timing is locked to h sync.
// - Clock lock is high only when both video and audio PLLs are locked.
// - Reference present is high while a valid reference is applied.
// - The active-low ref-lost pin is the inverse of reference present.
// - A set F, V or H mask bit drops that flag from reference lock.
module gssf_top (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [gssf_pkg::ADDR_W-1:0] addr_in,
    input wire logic [gssf_pkg::DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [gssf_pkg::DATA_W-1:0] rdata_out,
    input wire logic [gssf_pkg::CODE_W-1:0] video_standard_code_in,
    input wire logic ref_valid_in,
    input wire logic field_sync_input_in,
    input wire logic field_locked_in,
    input wire logic vert_locked_in,
    input wire logic horiz_locked_in,
    input wire logic video_pll_locked_in,
    input wire logic audio_pll_locked_in,
    output logic lock_lost_n_out,
    output logic ref_lost_n_out,
    output logic irq_out
);
    import gssf_pkg::*;

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    logic [15:0] std_disable_low;
    logic [15:0] std_disable_mid;
    logic [15:0] std_disable_high;
    logic [CTL_W-1:0] genlock_ctrl;
    logic [ST_W-1:0] lock_state_flags;
    logic [EV_W-1:0] event_status;
    logic [EV_W-1:0] event_mask;

    logic [63:0] std_vec_ext;
    logic std_allowed;
    logic [ST_W-1:0] next_flags;
    logic [EV_W-1:0] next_events;
    logic [EV_W-1:0] next_event_status;
    logic [DATA_W-1:0] next_rdata;
    logic event_read;

    // ----------------------------------------------------------------
    // Disable vector writes
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            std_disable_low <= RST_STD_DISABLE_LOW;
            std_disable_mid <= RST_STD_DISABLE_MID;
            std_disable_high <= RST_STD_DISABLE_HIGH;
        end else if (wr_in) begin
            // High word is kept whole; bits 47-39 are software's to set
            case (addr_in)
                OFS_STD_DISABLE_LOW: begin
                    std_disable_low <= wdata_in;
                end
                OFS_STD_DISABLE_MID: begin
                    std_disable_mid <= wdata_in;
                end
                OFS_STD_DISABLE_HIGH: begin
                    std_disable_high <= wdata_in;
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Genlock control (lock masks)
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            genlock_ctrl <= RST_GENLOCK_CTRL;
        end else if (wr_in && addr_in == OFS_GENLOCK_CTRL) begin
            genlock_ctrl <= wdata_in[CTL_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Standard filter
    // ----------------------------------------------------------------
    // Code zero means no reference detected, so it is never allowed
    assign std_vec_ext = {STD_PAD, std_disable_high, std_disable_mid,
        std_disable_low};
    assign std_allowed = (video_standard_code_in != 6'h00) &&
        !std_vec_ext[video_standard_code_in];

    // ----------------------------------------------------------------
    // Lock flag evaluation
    // ----------------------------------------------------------------
    always_comb begin
        next_flags = '0;
        next_flags[ST_REF_PRESENT] = ref_valid_in && std_allowed;
        next_flags[ST_CLOCK_LOCK] = video_pll_locked_in &&
            audio_pll_locked_in;
        next_flags[ST_H_LOCK] = horiz_locked_in && std_allowed;
        next_flags[ST_V_LOCK] = vert_locked_in && std_allowed;
        if (field_sync_input_in) begin
            next_flags[ST_F_LOCK] = field_locked_in && std_allowed;
        end else begin
            next_flags[ST_F_LOCK] = next_flags[ST_V_LOCK];
        end
        next_flags[ST_REF_LOCK] = next_flags[ST_CLOCK_LOCK] &&
            (next_flags[ST_H_LOCK] || genlock_ctrl[CTL_H_MASK]) &&
            (next_flags[ST_V_LOCK] || genlock_ctrl[CTL_V_MASK]) &&
            (next_flags[ST_F_LOCK] || genlock_ctrl[CTL_F_MASK]);
    end

    // Flags and pins share one flop stage so the pins never lag
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            lock_state_flags <= '0;
            lock_lost_n_out <= 1'b1;
            ref_lost_n_out <= 1'b1;
        end else begin
            lock_state_flags <= next_flags;
            lock_lost_n_out <= !next_flags[ST_REF_LOCK];
            ref_lost_n_out <= !next_flags[ST_REF_PRESENT];
        end
    end

    // ----------------------------------------------------------------
    // Events and interrupt
    // ----------------------------------------------------------------
    always_comb begin
        next_events = '0;
        next_events[EV_LOCK_GAINED] = next_flags[ST_REF_LOCK] &&
            !lock_state_flags[ST_REF_LOCK];
        next_events[EV_LOCK_LOST] = !next_flags[ST_REF_LOCK] &&
            lock_state_flags[ST_REF_LOCK];
        next_events[EV_REF_GAINED] = next_flags[ST_REF_PRESENT] &&
            !lock_state_flags[ST_REF_PRESENT];
        next_events[EV_REF_LOST] = !next_flags[ST_REF_PRESENT] &&
            lock_state_flags[ST_REF_PRESENT];
    end

    assign event_read = rd_in && addr_in == OFS_EVENT_STATUS;
    // New events win over a clearing read in the same cycle
    assign next_event_status = (event_read ? '0 : event_status) |
        next_events;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            event_status <= '0;
        end else begin
            event_status <= next_event_status;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            event_mask <= RST_EVENT_MASK;
        end else if (wr_in && addr_in == OFS_EVENT_MASK) begin
            event_mask <= wdata_in[EV_W-1:0];
        end
    end

    // Uses the mask as it will stand after this edge
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            irq_out <= 1'b0;
        end else if (wr_in && addr_in == OFS_EVENT_MASK) begin
            irq_out <= |(next_event_status & wdata_in[EV_W-1:0]);
        end else begin
            irq_out <= |(next_event_status & event_mask);
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    always_comb begin
        next_rdata = '0;
        case (addr_in)
            OFS_STD_DISABLE_LOW: begin
                next_rdata = std_disable_low;
            end
            OFS_STD_DISABLE_MID: begin
                next_rdata = std_disable_mid;
            end
            OFS_STD_DISABLE_HIGH: begin
                next_rdata = std_disable_high;
            end
            OFS_LOCK_STATE_FLAGS: begin
                // Read only; upper bits stay zero
                next_rdata[ST_W-1:0] = lock_state_flags;
            end
            OFS_GENLOCK_CTRL: begin
                next_rdata[CTL_W-1:0] = genlock_ctrl;
            end
            OFS_EVENT_STATUS: begin
                next_rdata[EV_W-1:0] = event_status;
            end
            OFS_EVENT_MASK: begin
                next_rdata[EV_W-1:0] = event_mask;
            end
            default: begin
                next_rdata = '0;
            end
        endcase
    end

    // Data stands only in the cycle after the read strobe
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rdata_out <= '0;
        end else if (rd_in) begin
            rdata_out <= next_rdata;
        end else begin
            rdata_out <= '0;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);

    sequence s_lock_drop;
        lock_state_flags[ST_REF_LOCK] ##1 !lock_state_flags[ST_REF_LOCK];
    endsequence

    sequence s_status_read;
        rd_in && addr_in == OFS_LOCK_STATE_FLAGS;
    endsequence

    sequence s_lock_rise;
        !lock_state_flags[ST_REF_LOCK] ##1 lock_state_flags[ST_REF_LOCK];
    endsequence

    sequence s_ref_rise;
        !lock_state_flags[ST_REF_PRESENT] ##1
            lock_state_flags[ST_REF_PRESENT];
    endsequence

    sequence s_ref_drop;
        lock_state_flags[ST_REF_PRESENT] ##1
            !lock_state_flags[ST_REF_PRESENT];
    endsequence

    a_disabled_std_blocks: assert property (
        !std_allowed |=> lock_state_flags[ST_REF_PRESENT] == 1'b0 &&
            lock_state_flags[ST_H_LOCK] == 1'b0 &&
            lock_state_flags[ST_V_LOCK] == 1'b0)
        else $error("Disabled standard raised a flag");

    a_vector_split_high: assert property (
        wr_in && addr_in == OFS_STD_DISABLE_HIGH |=>
            std_disable_high == $past(wdata_in) &&
            $stable(std_disable_low) && $stable(std_disable_mid))
        else $error("High vector write misplaced");

    a_ref_lock_masks: assert property (
        lock_state_flags[ST_REF_LOCK] |->
            lock_state_flags[ST_CLOCK_LOCK] &&
            (lock_state_flags[ST_F_LOCK] || $past(genlock_ctrl[CTL_F_MASK])) &&
            (lock_state_flags[ST_V_LOCK] || $past(genlock_ctrl[CTL_V_MASK])) &&
            (lock_state_flags[ST_H_LOCK] || $past(genlock_ctrl[CTL_H_MASK])))
        else $error("Reference lock without all lock terms");

    a_lock_pin_inverse: assert property (
        lock_lost_n_out == !lock_state_flags[ST_REF_LOCK])
        else $error("Lock-lost pin disagrees with flag");

    a_field_lock_sync: assert property (
        field_sync_input_in && field_locked_in && std_allowed |=>
            lock_state_flags[ST_F_LOCK])
        else $error("Field lock missed");

    a_field_copies_vert: assert property (
        !field_sync_input_in |=>
            lock_state_flags[ST_F_LOCK] == lock_state_flags[ST_V_LOCK])
        else $error("Field lock does not follow vertical lock");

    a_vert_lock_flag: assert property (
        vert_locked_in && std_allowed |=> lock_state_flags[ST_V_LOCK])
        else $error("Vertical lock missed");

    a_horiz_lock_flag: assert property (
        horiz_locked_in && std_allowed |=> lock_state_flags[ST_H_LOCK])
        else $error("Horizontal lock missed");

    a_clock_lock_and: assert property (
        ##1 lock_state_flags[ST_CLOCK_LOCK] ==
            $past(video_pll_locked_in && audio_pll_locked_in))
        else $error("Clock lock does not match both PLLs");

    a_ref_present_flag: assert property (
        ref_valid_in && std_allowed |=> lock_state_flags[ST_REF_PRESENT])
        else $error("Reference present missed");

    a_ref_pin_inverse: assert property (
        ref_lost_n_out == !lock_state_flags[ST_REF_PRESENT])
        else $error("Reference-lost pin disagrees with flag");

    a_status_reserved_zero: assert property (
        s_status_read |=> rdata_out[DATA_W-1:ST_W] == '0 &&
            rdata_out[ST_W-1:0] == $past(lock_state_flags))
        else $error("Status read wrong or reserved bits set");

    a_code_zero_blocks: assert property (
        video_standard_code_in == 6'h00 |=>
            !lock_state_flags[ST_REF_PRESENT] && !lock_state_flags[ST_F_LOCK])
        else $error("Code zero raised a flag");

    a_lock_loss_event: assert property (
        s_lock_drop |-> event_status[EV_LOCK_LOST])
        else $error("Lock loss not recorded");

    a_lock_gain_event: assert property (
        s_lock_rise |-> event_status[EV_LOCK_GAINED])
        else $error("Lock gain not recorded");

    a_ref_gain_event: assert property (
        s_ref_rise |-> event_status[EV_REF_GAINED])
        else $error("Reference gain not recorded");

    a_ref_loss_event: assert property (
        s_ref_drop |-> event_status[EV_REF_LOST])
        else $error("Reference loss not recorded");

    // Read data must not linger past its one cycle
    a_read_data_idle: assert property (
        !rd_in |=> rdata_out == '0)
        else $error("Read data outside read cycle");

    a_vector_split_low: assert property (
        wr_in && addr_in == OFS_STD_DISABLE_LOW |=>
            std_disable_low == $past(wdata_in) &&
            $stable(std_disable_mid) && $stable(std_disable_high))
        else $error("Low vector write misplaced");

    a_vector_split_mid: assert property (
        wr_in && addr_in == OFS_STD_DISABLE_MID |=>
            std_disable_mid == $past(wdata_in) &&
            $stable(std_disable_low) && $stable(std_disable_high))
        else $error("Middle vector write misplaced");

    a_irq_follows_events: assert property (
        irq_out == |(event_status & event_mask))
        else $error("Interrupt disagrees with masked events");

endmodule : gssf_top

/* File: verilog/gssf_pkg.sv */
// Shared constants for the genlock status and standard filter block
package gssf_pkg;
    // ----------------------------------------------------------------
    // Bus geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int CODE_W = 6;
    localparam int VEC_W = 48;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_STD_DISABLE_LOW = 8'h11;
    localparam logic [7:0] OFS_STD_DISABLE_MID = 8'h12;
    localparam logic [7:0] OFS_STD_DISABLE_HIGH = 8'h13;
    localparam logic [7:0] OFS_RESERVED_GAP = 8'h14;
    localparam logic [7:0] OFS_LOCK_STATE_FLAGS = 8'h15;
    localparam logic [7:0] OFS_GENLOCK_CTRL = 8'h16;
    localparam logic [7:0] OFS_EVENT_STATUS = 8'h20;
    localparam logic [7:0] OFS_EVENT_MASK = 8'h21;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] RST_STD_DISABLE_LOW = 16'hF800;
    localparam logic [15:0] RST_STD_DISABLE_MID = 16'hFFFF;
    localparam logic [15:0] RST_STD_DISABLE_HIGH = 16'hFFFF;
    localparam logic [6:0] RST_GENLOCK_CTRL = 7'h00;
    localparam logic [3:0] RST_EVENT_MASK = 4'h0;
    // Codes beyond the vector always count as disabled
    localparam logic [15:0] STD_PAD = 16'hFFFF;

    // ----------------------------------------------------------------
    // Status bit positions
    // ----------------------------------------------------------------
    localparam int ST_REF_PRESENT = 0;
    localparam int ST_CLOCK_LOCK = 1;
    localparam int ST_H_LOCK = 2;
    localparam int ST_V_LOCK = 3;
    localparam int ST_F_LOCK = 4;
    localparam int ST_REF_LOCK = 5;
    localparam int ST_W = 6;

    // Control register fields
    localparam int CTL_H_MASK = 2;
    localparam int CTL_V_MASK = 3;
    localparam int CTL_F_MASK = 4;
    localparam int CTL_W = 7;

    // Event bits
    localparam int EV_LOCK_GAINED = 0;
    localparam int EV_LOCK_LOST = 1;
    localparam int EV_REF_GAINED = 2;
    localparam int EV_REF_LOST = 3;
    localparam int EV_W = 4;
endpackage : gssf_pkg

/* File: test/tb_top.sv */
// Self-checking bench for the genlock status and standard filter block
`timescale 1ns/10ps
module tb_top;
    import gssf_pkg::*;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [ADDR_W-1:0] addr_in = '0;
    logic [DATA_W-1:0] wdata_in = '0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [DATA_W-1:0] rdata_out;
    logic [CODE_W-1:0] code = '0;
    logic ref_valid = 1'b0;
    logic field_sync = 1'b0;
    logic f_lk = 1'b0;
    logic v_lk = 1'b0;
    logic h_lk = 1'b0;
    logic vpll = 1'b0;
    logic apll = 1'b0;
    logic lock_lost_n_out;
    logic ref_lost_n_out;
    logic irq_out;
    int error_cnt = 0;
    int check_count = 0;
    integer seed = 41240;
    logic [VEC_W-1:0] vec = {RST_STD_DISABLE_HIGH, RST_STD_DISABLE_MID,
        RST_STD_DISABLE_LOW};
    logic [6:0] ctrl = '0;
    logic [15:0] rd_val;
    logic [15:0] e;
    logic [15:0] r;
    logic [15:0] r2;

    gssf_top gssf_top_inst (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .addr_in(addr_in),
        .wdata_in(wdata_in),
        .wr_in(wr_in),
        .rd_in(rd_in),
        .rdata_out(rdata_out),
        .video_standard_code_in(code),
        .ref_valid_in(ref_valid),
        .field_sync_input_in(field_sync),
        .field_locked_in(f_lk),
        .vert_locked_in(v_lk),
        .horiz_locked_in(h_lk),
        .video_pll_locked_in(vpll),
        .audio_pll_locked_in(apll),
        .lock_lost_n_out(lock_lost_n_out),
        .ref_lost_n_out(ref_lost_n_out),
        .irq_out(irq_out)
    );

    // ----------------------------------------------------------------
    // Clock, verdict and watchdog
    // ----------------------------------------------------------------
    initial begin
        forever #50 clk_in = ~clk_in;
    end

    task automatic end_sim();
        if (error_cnt == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    // Whole run is a few thousand cycles; allow ample margin
    initial begin
        #2000000;
        error_cnt++;
        end_sim();
    end

    // ----------------------------------------------------------------
    // Bus tasks, compares and expectation
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask : wr

    // Data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        rd_val = rdata_out;
    endtask : rd

    task automatic settle(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : settle

    task automatic drive(input logic [12:0] v);
        @(posedge clk_in);
        {ref_valid, field_sync, f_lk, v_lk, h_lk, vpll, apll, code} <= v;
    endtask : drive

    task automatic chk16(input string n, input logic [15:0] x,
                         input logic [15:0] s);
        check_count++;
        if (s !== x) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, x, s);
        end
    endtask : chk16

    task automatic chk1(input string n, input logic x, input logic s);
        check_count++;
        if (s !== x) begin
            error_cnt++;
            $display("mismatch %s expected %b seen %b", n, x, s);
        end
    endtask : chk1

    function automatic logic [15:0] exp_status();
        logic ok;
        logic [5:0] s;
        ok = (code != 0) && (code < VEC_W) && !vec[code];
        s[0] = ref_valid & ok;
        s[1] = vpll & apll;
        s[2] = h_lk & ok;
        s[3] = v_lk & ok;
        s[4] = field_sync ? (f_lk & ok) : s[3];
        s[5] = s[1] & (s[2] | ctrl[2]) & (s[3] | ctrl[3]) & (s[4] | ctrl[4]);
        return {10'h000, s};
    endfunction : exp_status

    task automatic chk_vec();
        rd(OFS_STD_DISABLE_LOW);
        chk16("vec_low", vec[15:0], rd_val);
        rd(OFS_STD_DISABLE_MID);
        chk16("vec_mid", vec[31:16], rd_val);
        rd(OFS_STD_DISABLE_HIGH);
        chk16("vec_high", vec[47:32], rd_val);
    endtask : chk_vec

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        chk_vec();
        rd(OFS_GENLOCK_CTRL);
        chk16("ctrl_reset", 16'h0000, rd_val);
        rd(OFS_EVENT_MASK);
        chk16("mask_reset", 16'h0000, rd_val);
        // Random standards, vectors, masks and lock inputs
        for (int i = 0; i < 150; i++) begin
            r = 16'($random(seed));
            r2 = 16'($random(seed));
            vec[15:0] = 16'($random(seed));
            vec[31:16] = 16'($random(seed));
            vec[47:32] = {9'h1FF, r[6:0]};
            case (i)
                0: begin
                    vec[26] = 1'b0;
                    r2[5:0] = 6'h1A;
                end
                1: begin
                    vec[5] = 1'b1;
                    r2[5:0] = 6'h05;
                end
                2: r2[5:0] = 6'h00;
                3: r2[5:0] = 6'h32;
                default: ;
            endcase
            if (i < 4) begin
                r2[12:6] = 7'h7F;
            end
            ctrl = r[13:7];
            wr(OFS_STD_DISABLE_LOW, vec[15:0]);
            wr(OFS_STD_DISABLE_MID, vec[31:16]);
            wr(OFS_STD_DISABLE_HIGH, vec[47:32]);
            wr(OFS_GENLOCK_CTRL, {9'h000, ctrl});
            drive(r2[12:0]);
            // Writes to status must be ignored
            wr(OFS_LOCK_STATE_FLAGS, 16'hFFFF);
            settle(3);
            e = exp_status();
            rd(OFS_LOCK_STATE_FLAGS);
            chk16("status", e, rd_val);
            chk1("present", e[0], rd_val[0]);
            chk1("clock_lock", e[1], rd_val[1]);
            chk1("h_lock", e[2], rd_val[2]);
            chk1("v_lock", e[3], rd_val[3]);
            chk1("f_lock", e[4], rd_val[4]);
            chk1("ref_lock", e[5], rd_val[5]);
            chk1("lock_lost_n", ~e[5], lock_lost_n_out);
            chk1("ref_lost_n", ~e[0], ref_lost_n_out);
            if (i % 10 == 0) begin
                chk_vec();
                rd(OFS_RESERVED_GAP);
                chk16("reserved", 16'h0000, rd_val);
                rd(8'h3F);
                chk16("unmapped", 16'h0000, rd_val);
                rd(OFS_GENLOCK_CTRL);
                chk16("ctrl", {9'h000, ctrl}, rd_val);
            end
        end
        // Interrupt: raise, clear by read, mask, unmask
        vec = {RST_STD_DISABLE_HIGH, RST_STD_DISABLE_MID, RST_STD_DISABLE_LOW};
        ctrl = '0;
        wr(OFS_STD_DISABLE_LOW, vec[15:0]);
        wr(OFS_STD_DISABLE_MID, vec[31:16]);
        wr(OFS_STD_DISABLE_HIGH, vec[47:32]);
        wr(OFS_GENLOCK_CTRL, 16'h0000);
        drive(13'h0001);
        settle(3);
        rd(OFS_EVENT_STATUS);
        wr(OFS_EVENT_MASK, 16'h000F);
        settle(2);
        chk1("irq_idle", 1'b0, irq_out);
        drive({7'b1011111, 6'h01});
        settle(3);
        chk1("irq_raised", 1'b1, irq_out);
        rd(OFS_LOCK_STATE_FLAGS);
        chk16("status_locked", 16'h003F, rd_val);
        rd(OFS_EVENT_STATUS);
        chk16("events_gain", 16'h0005, rd_val);
        settle(2);
        chk1("irq_cleared", 1'b0, irq_out);
        wr(OFS_EVENT_MASK, 16'h0000);
        drive({7'b0011011, 6'h01});
        settle(3);
        chk1("irq_masked", 1'b0, irq_out);
        wr(OFS_EVENT_MASK, 16'hFFFF);
        settle(2);
        chk1("irq_unmasked", 1'b1, irq_out);
        rd(OFS_EVENT_MASK);
        chk16("mask", 16'h000F, rd_val);
        rd(OFS_EVENT_STATUS);
        chk16("events_loss", 16'h000A, rd_val);
        rd(OFS_EVENT_STATUS);
        chk16("events_empty", 16'h0000, rd_val);
        end_sim();
    end
endmodule : tb_top
